// ### rtl/lccr_pkg.sv
// Constants and types shared by the channel configuration register files.
package lccr_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SRST_MAX_NS = 1000;
  localparam int SRST_CYC = SRST_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(SRST_CYC + 1);
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int CH_NUM = 16;
  localparam logic [4:0] CH0_BLK = 5'h1f;
  localparam logic [4:0] LAST_BLK = 5'h0e;
  localparam logic [5:0] CHANNEL_CONFIG_IDX = 6'h01;
  localparam logic [5:0] TJA_IDX = 6'h02;
  localparam logic [5:0] RJA_IDX = 6'h03;
  localparam logic [1:0] CHANNEL_CONFIG_SEL = 2'h1;
  localparam logic [1:0] TJA_SEL = 2'h2;
  localparam logic [1:0] RJA_SEL = 2'h3;
  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int STD_BIT = 0;
  localparam int RST_BIT = 1;
  localparam int BW_BIT = 0;
  localparam int DP_LO = 1;
  localparam int DP_HI = 2;
  localparam int EN_BIT = 3;
  localparam int LIM_BIT = 4;
  localparam logic [7:0] JA_MASK = 8'h1f;
  localparam logic [7:0] CHANNEL_CONFIG_RST = 8'h00;
  localparam logic [7:0] TJA_RST = 8'h00;
  localparam logic [7:0] RJA_RST = 8'h00;
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  // Corner frequencies in hundredths of a hertz.
  localparam logic [9:0] CORNER_T1_HI = 10'h1f4;
  localparam logic [9:0] CORNER_E1_HI = 10'h2a5;
  localparam logic [9:0] CORNER_T1_LO = 10'h07e;
  localparam logic [9:0] CORNER_E1_LO = 10'h057;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] channel_config;
    logic [7:0] transmit_jitter_config;
    logic [7:0] receive_jitter_config;
  } lccr_regs_t;
  typedef struct packed {
    logic en;
    logic [1:0] sel;
    logic [7:0] data;
  } lccr_wr_t;
  typedef struct packed {
    logic hit;
    logic [3:0] ch;
    logic [1:0] sel;
  } lccr_dec_t;
  typedef struct packed {
    logic en;
    logic limit;
    logic [7:0] depth;
    logic [9:0] corner;
  } lccr_ja_cfg_t;
  typedef struct packed {
    logic soft_rst;
    logic e1;
    lccr_ja_cfg_t tx;
    lccr_ja_cfg_t rx;
  } lccr_ch_cfg_t;
  localparam lccr_regs_t REGS_RST = '{CHANNEL_CONFIG_RST, TJA_RST, RJA_RST};
  localparam lccr_ja_cfg_t JA_CFG_RST =
    '{1'b0, 1'b0, DEPTH_128, CORNER_T1_HI};
  localparam lccr_ch_cfg_t CFG_RST =
    '{1'b0, 1'b0, JA_CFG_RST, JA_CFG_RST};
endpackage : lccr_pkg

// ### rtl/lccr_chan.sv
// Register set and decoded settings of one line channel.
`timescale 1ns/1ns
module lccr_chan (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire lccr_pkg::lccr_wr_t wr_i,
  input wire logic hw_mode_strap_pin_i,
  input wire logic hw_e1_i,
  output lccr_pkg::lccr_regs_t regs_o,
  output lccr_pkg::lccr_ch_cfg_t cfg_o
);
  logic [lccr_pkg::CNT_W-1:0] cnt;
  logic [lccr_pkg::CNT_W-1:0] next_cnt;
  lccr_pkg::lccr_regs_t next_regs;
  lccr_pkg::lccr_ch_cfg_t next_cfg;
  logic e1_eff;
  logic restart;

  function automatic lccr_pkg::lccr_ja_cfg_t ja_decode(
    input logic [7:0] r, input logic e1);
    ja_decode.en = r[lccr_pkg::EN_BIT];
    ja_decode.limit = r[lccr_pkg::LIM_BIT];
    if (r[lccr_pkg::DP_HI]) begin
      ja_decode.depth = lccr_pkg::DEPTH_32;
    end else if (r[lccr_pkg::DP_LO]) begin
      ja_decode.depth = lccr_pkg::DEPTH_64;
    end else begin
      ja_decode.depth = lccr_pkg::DEPTH_128;
    end
    case ({e1, r[lccr_pkg::BW_BIT]})
      2'h0: ja_decode.corner = lccr_pkg::CORNER_T1_HI;
      2'h1: ja_decode.corner = lccr_pkg::CORNER_T1_LO;
      2'h2: ja_decode.corner = lccr_pkg::CORNER_E1_HI;
      default: ja_decode.corner = lccr_pkg::CORNER_E1_LO;
    endcase
  endfunction : ja_decode

  assign restart = wr_i.en && wr_i.sel == lccr_pkg::CHANNEL_CONFIG_SEL &&
    wr_i.data[lccr_pkg::RST_BIT];

  always_comb begin
    next_regs = regs_o;
    next_cnt = cnt;
    if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      if (cnt == lccr_pkg::CNT_W'(1)) begin
        next_regs.channel_config[lccr_pkg::RST_BIT] = 1'b0;
      end
    end
    if (wr_i.en) begin
      case (wr_i.sel)
        lccr_pkg::CHANNEL_CONFIG_SEL: begin
          next_regs.channel_config[lccr_pkg::STD_BIT] = wr_i.data[0];
        end
        lccr_pkg::TJA_SEL: next_regs.transmit_jitter_config = wr_i.data & lccr_pkg::JA_MASK;
        lccr_pkg::RJA_SEL: next_regs.receive_jitter_config = wr_i.data & lccr_pkg::JA_MASK;
        default: ;
      endcase
    end
    if (restart) begin
      next_regs.channel_config[lccr_pkg::RST_BIT] = 1'b1;
      next_cnt = lccr_pkg::CNT_W'(lccr_pkg::SRST_CYC);
    end
    // A running soft reset holds both attenuator settings at default.
    if (next_regs.channel_config[lccr_pkg::RST_BIT]) begin
      next_regs.transmit_jitter_config = lccr_pkg::TJA_RST;
      next_regs.receive_jitter_config = lccr_pkg::RJA_RST;
    end
    e1_eff = hw_mode_strap_pin_i ? hw_e1_i :
      regs_o.channel_config[lccr_pkg::STD_BIT];
    next_cfg.soft_rst = regs_o.channel_config[lccr_pkg::RST_BIT];
    next_cfg.e1 = e1_eff;
    next_cfg.tx = ja_decode(regs_o.transmit_jitter_config, e1_eff);
    next_cfg.rx = ja_decode(regs_o.receive_jitter_config, e1_eff);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      regs_o <= lccr_pkg::REGS_RST;
      cnt <= '0;
      cfg_o <= lccr_pkg::CFG_RST;
    end else if (ce_i) begin
      regs_o <= next_regs;
      cnt <= next_cnt;
      cfg_o <= next_cfg;
    end
  end

  chk_srst_bound: assert property (@(posedge clk_i) disable iff (srst_i)
    regs_o.channel_config[lccr_pkg::RST_BIT] |-> cnt != '0 &&
    cnt <= lccr_pkg::SRST_CYC)
    else $error("soft reset counter out of range");
  chk_srst_step: assert property (@(posedge clk_i) disable iff (srst_i)
    cnt != '0 && ce_i && !restart |=>
    cnt == $past(cnt) - 1'b1 && (cnt != '0 ||
    !regs_o.channel_config[lccr_pkg::RST_BIT]))
    else $error("soft reset did not count down and clear");
endmodule : lccr_chan

// ### rtl/lccr_regs.sv
// AXI4-Lite register bank holding the per-channel line configuration.
`timescale 1ns/1ns
// Notes on behaviour
// - Channels 1-15 repeat every 0x40 words; channel 0 sits at 0x7C0.
// - Writing one to the soft reset bit starts a reset of that channel.
// - A channel soft reset finishes within one microsecond.
// - The soft reset bit clears itself when the reset is done.
// - Standard select bit acts only while the mode strap is low.
// - Standard select zero means T1/J1 (default), one means E1.
// - Channel soft reset keeps the standard select bit; device reset clears it.
// - Transmit attenuator off when its enable is zero (default), on when one.
// - Transmit limit bit adjusts output rate near FIFO full or empty.
// - Transmit FIFO depth: 00 gives 128, 01 gives 64, 1x gives 32.
// - Transmit corner bit: 5 or 6.77 Hz when zero, 1.26 or 0.87 Hz.
// - Receive attenuator off when its enable is zero (default), on when one.
// - Receive limit bit adjusts output rate near FIFO full or empty.
// - Receive FIFO depth: 00 gives 128, 01 gives 64, 1x gives 32.
// - Receive corner bit: 5 or 6.77 Hz when zero, 1.26 or 0.87 Hz.
// - Configuration and attenuator registers reset to all zeros.
module lccr_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [lccr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [lccr_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic hw_mode_strap_pin_i,
  input wire logic hw_e1_i,
  output lccr_pkg::lccr_ch_cfg_t cfg_o [lccr_pkg::CH_NUM]
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  lccr_pkg::lccr_regs_t ch_regs [lccr_pkg::CH_NUM];
  lccr_pkg::lccr_wr_t ch_wr [lccr_pkg::CH_NUM];
  lccr_pkg::lccr_dec_t wdec;
  lccr_pkg::lccr_dec_t rdec;
  lccr_pkg::lccr_regs_t rsel;
  logic aw_got;
  logic w_got;
  logic [lccr_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstb_q;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_wr;
  logic [lccr_pkg::ADDR_W-1:0] wa;
  logic [7:0] wd;
  logic wstb;
  logic [7:0] rbyte;
  logic next_aw_got;
  logic next_w_got;
  logic [lccr_pkg::ADDR_W-1:0] next_awaddr_q;
  logic [7:0] next_wdata_q;
  logic next_wstb_q;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // The register index is the byte address divided by four.
  function automatic lccr_pkg::lccr_dec_t decode(
    input logic [lccr_pkg::ADDR_W-1:0] addr);
    logic [4:0] blk;
    logic [5:0] off;
    decode = '0;
    blk = addr[12:8];
    off = addr[7:2];
    if (off < lccr_pkg::CHANNEL_CONFIG_IDX || off > lccr_pkg::RJA_IDX) begin
      decode.hit = 1'b0;
    end else if (blk == lccr_pkg::CH0_BLK) begin
      decode.hit = 1'b1;
      decode.ch = 4'h0;
      decode.sel = off[1:0];
    end else if (blk <= lccr_pkg::LAST_BLK) begin
      decode.hit = 1'b1;
      decode.ch = blk[3:0] + 4'h1;
      decode.sel = off[1:0];
    end
  endfunction : decode

  // ------------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------------
  always_comb begin
    aw_fire = s_axi_awvalid_i && s_axi_awready_o && ce_i;
    w_fire = s_axi_wvalid_i && s_axi_wready_o && ce_i;
    wa = aw_got ? awaddr_q : s_axi_awaddr_i;
    wd = w_got ? wdata_q : s_axi_wdata_i[7:0];
    wstb = w_got ? wstb_q : s_axi_wstrb_i[0];
    wdec = decode(wa);
    do_wr = (aw_got || aw_fire) && (w_got || w_fire) &&
      !s_axi_bvalid_o && ce_i;
    next_aw_got = aw_got || aw_fire;
    next_w_got = w_got || w_fire;
    next_awaddr_q = aw_fire ? s_axi_awaddr_i : awaddr_q;
    next_wdata_q = w_fire ? s_axi_wdata_i[7:0] : wdata_q;
    next_wstb_q = w_fire ? s_axi_wstrb_i[0] : wstb_q;
    next_bvalid = s_axi_bvalid_o && !s_axi_bready_i;
    next_bresp = s_axi_bresp_o;
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wdec.hit ? lccr_pkg::RESP_OKAY :
        lccr_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstb_q <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= lccr_pkg::RESP_OKAY;
    end else if (ce_i) begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstb_q <= next_wstb_q;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o <= next_wready;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o <= next_bresp;
    end
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  always_comb begin
    ar_fire = s_axi_arvalid_i && s_axi_arready_o && ce_i;
    rdec = decode(s_axi_araddr_i);
    rsel = ch_regs[rdec.ch];
    if (rdec.sel == lccr_pkg::CHANNEL_CONFIG_SEL) begin
      rbyte = rsel.channel_config;
    end else if (rdec.sel == lccr_pkg::TJA_SEL) begin
      rbyte = rsel.transmit_jitter_config;
    end else begin
      rbyte = rsel.receive_jitter_config;
    end
    next_rvalid = s_axi_rvalid_o && !s_axi_rready_i;
    next_rdata = s_axi_rdata_o;
    next_rresp = s_axi_rresp_o;
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rdata = rdec.hit ? {24'h000000, rbyte} : 32'h00000000;
      next_rresp = rdec.hit ? lccr_pkg::RESP_OKAY :
        lccr_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= lccr_pkg::RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rresp;
    end
  end

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  for (genvar g = 0; g < lccr_pkg::CH_NUM; g++) begin : g_ch
    assign ch_wr[g] = '{en: do_wr && wdec.hit && wstb &&
      wdec.ch == 4'(g), sel: wdec.sel, data: wd};

    lccr_chan u_chan (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .wr_i(ch_wr[g]),
      .hw_mode_strap_pin_i(hw_mode_strap_pin_i),
      .hw_e1_i(hw_e1_i),
      .regs_o(ch_regs[g]),
      .cfg_o(cfg_o[g])
    );

    sequence seq_soft_wr;
      ch_wr[g].en && ch_wr[g].sel == lccr_pkg::CHANNEL_CONFIG_SEL &&
        ch_wr[g].data[lccr_pkg::RST_BIT];
    endsequence
    sequence seq_soft_seen;
      ch_regs[g].channel_config[lccr_pkg::RST_BIT] && ch_regs[g].transmit_jitter_config == 8'h00
        ##1 cfg_o[g].soft_rst;
    endsequence

    chk_soft_start: assert property (@(posedge clk_i)
      disable iff (srst_i || !ce_i)
      seq_soft_wr |=> seq_soft_seen)
      else $error("soft reset write did not start a reset");
    chk_soft_keeps_std: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ch_regs[g].channel_config[lccr_pkg::RST_BIT] && !ch_wr[g].en |=>
      $stable(ch_regs[g].channel_config[lccr_pkg::STD_BIT]))
      else $error("soft reset changed the standard select");
    chk_regs_reset: assert property (@(posedge clk_i)
      srst_i |=> ch_regs[g] == lccr_pkg::REGS_RST &&
      !cfg_o[g].e1)
      else $error("registers not at default after reset");
    chk_std_soft: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i && !hw_mode_strap_pin_i |=>
      cfg_o[g].e1 == $past(ch_regs[g].channel_config[lccr_pkg::STD_BIT]))
      else $error("standard select not applied");
    chk_std_strap: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i && hw_mode_strap_pin_i |=>
      cfg_o[g].e1 == $past(hw_e1_i))
      else $error("standard select not ignored under strap");
    chk_tx_depth: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i |=> cfg_o[g].tx.depth ==
      ($past(ch_regs[g].transmit_jitter_config[2]) ? 8'h20 :
      $past(ch_regs[g].transmit_jitter_config[1]) ? 8'h40 : 8'h80))
      else $error("transmit FIFO depth wrong");
    chk_rx_depth: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i ##0 ch_regs[g].receive_jitter_config[2:1] == 2'h1 |=>
      cfg_o[g].rx.depth == 8'h40)
      else $error("receive FIFO depth wrong");
    chk_tx_corner: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i && !hw_mode_strap_pin_i && !ch_regs[g].channel_config[0] |=>
      cfg_o[g].tx.corner == ($past(ch_regs[g].transmit_jitter_config[0]) ?
      10'h07e : 10'h1f4))
      else $error("transmit corner frequency wrong");
    chk_rx_corner: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i && !hw_mode_strap_pin_i && ch_regs[g].channel_config[0] |=>
      cfg_o[g].rx.corner == ($past(ch_regs[g].receive_jitter_config[0]) ?
      10'h057 : 10'h2a5))
      else $error("receive corner frequency wrong");
    chk_tx_enable: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i |=> cfg_o[g].tx.en == $past(ch_regs[g].transmit_jitter_config[3]) &&
      cfg_o[g].tx.limit == $past(ch_regs[g].transmit_jitter_config[4]))
      else $error("transmit enable or limit not applied");
    chk_rx_enable: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ce_i |=> cfg_o[g].rx.en == $past(ch_regs[g].receive_jitter_config[3]) &&
      cfg_o[g].rx.limit == $past(ch_regs[g].receive_jitter_config[4]))
      else $error("receive enable or limit not applied");
  end

  // ------------------------------------------------------------------
  // Bus checks
  // ------------------------------------------------------------------
  chk_wr_unmapped: assert property (@(posedge clk_i)
    disable iff (srst_i)
    do_wr && !wdec.hit |=> s_axi_bvalid_o &&
    s_axi_bresp_o == lccr_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_map_ch0: assert property (@(posedge clk_i)
    disable iff (srst_i)
    ar_fire && s_axi_araddr_i == 13'h1f04 |=>
    s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(ch_regs[0].channel_config))
    else $error("channel zero register misplaced");
  chk_rd_reserved: assert property (@(posedge clk_i)
    disable iff (srst_i)
    s_axi_rvalid_o |-> s_axi_rdata_o[31:5] == 27'h0000000)
    else $error("reserved read bits not zero");
endmodule : lccr_regs

// ### tb/lccr_regs_tb_top.sv
// Self-checking bench for the channel configuration register bank.
`timescale 1ns/1ns
module lccr_regs_tb_top;
  // ------------------------------------------------------------------
  // Signals and design instance
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [12:0] a;
    logic [31:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } lccr_row_t;
  // Ordinary accesses: address, written word, read-back byte, response.
  localparam lccr_row_t ROWS [11] = '{
    '{13'h0004, 32'hfffffffd, 8'h01, lccr_pkg::RESP_OKAY},
    '{13'h0008, 32'hffffffff, 8'h1f, lccr_pkg::RESP_OKAY},
    '{13'h000c, 32'h00000015, 8'h15, lccr_pkg::RESP_OKAY},
    '{13'h0e0c, 32'h0000000a, 8'h0a, lccr_pkg::RESP_OKAY},
    '{13'h0d0c, 32'h00000000, 8'h00, lccr_pkg::RESP_OKAY},
    '{13'h1f04, 32'h000000fd, 8'h01, lccr_pkg::RESP_OKAY},
    '{13'h1f08, 32'h00000013, 8'h13, lccr_pkg::RESP_OKAY},
    '{13'h0000, 32'h000000ff, 8'h00, lccr_pkg::RESP_SLVERR},
    '{13'h0010, 32'h000000ff, 8'h00, lccr_pkg::RESP_SLVERR},
    '{13'h0f04, 32'h000000ff, 8'h00, lccr_pkg::RESP_SLVERR},
    '{13'h1f10, 32'h000000ff, 8'h00, lccr_pkg::RESP_SLVERR}
  };
  logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, strap = 1'b0, hw_e1 = 1'b0;
  logic [12:0] awaddr = 13'h0000, araddr = 13'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  lccr_pkg::lccr_ch_cfg_t cfg [lccr_pkg::CH_NUM];
  int fails = 0, n_compared = 0, cyc = 0;

  lccr_regs u_lccr_regs (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .hw_mode_strap_pin_i(strap),
    .hw_e1_i(hw_e1), .cfg_o(cfg)
  );

  always #5 clk_i = ~clk_i;

  // The whole run takes under a thousand cycles; this cuts a hang short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  function automatic logic [12:0] adr(input int ch, input int off);
    logic [12:0] b;
    b = (ch == 0) ? 13'h07c0 : 13'(ch - 1) << 6;
    adr = (b + 13'(off)) << 2;
  endfunction : adr

  function automatic lccr_pkg::lccr_ja_cfg_t exp_ja(input logic [4:0] v,
                                                     input logic e1);
    exp_ja.en = v[3];
    exp_ja.limit = v[4];
    exp_ja.depth = v[2] ? lccr_pkg::DEPTH_32 :
                   (v[1] ? lccr_pkg::DEPTH_64 : lccr_pkg::DEPTH_128);
    if (v[0]) begin
      exp_ja.corner = e1 ? lccr_pkg::CORNER_E1_LO : lccr_pkg::CORNER_T1_LO;
    end else begin
      exp_ja.corner = e1 ? lccr_pkg::CORNER_E1_HI : lccr_pkg::CORNER_T1_HI;
    end
  endfunction : exp_ja

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [12:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awready === 1'b1) aw_ok = 1'b1;
      if (wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle
  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    settle(1);
    for (int i = 0; i < 16; i++) begin
      cmp(cfg[i], lccr_pkg::CFG_RST, "reset settings");
    end
    for (int o = 1; o < 4; o++) begin
      rd(adr(7, o), d, r);
      cmp(d, 32'h00000000, "reset register");
    end
    foreach (ROWS[k]) begin
      wr(ROWS[k].a, ROWS[k].d, r);
      cmp(r, ROWS[k].r, "write response");
      rd(ROWS[k].a, d, r);
      cmp(d, ROWS[k].e, "read data");
      cmp(r, ROWS[k].r, "read response");
    end
    // Every attenuator code in both line standards.
    for (int s = 0; s < 2; s++) begin
      wr(adr(2, 1), 32'(s), r);
      for (int v = 0; v < 32; v++) begin
        wr(adr(2, 2), 32'(v), r);
        wr(adr(2, 3), 32'(31 - v), r);
        settle(1);
        cmp(cfg[2].tx, exp_ja(5'(v), s[0]), "tx decode");
        cmp(cfg[2].rx, exp_ja(5'(31 - v), s[0]), "rx decode");
        cmp(cfg[2].e1, s[0], "standard");
      end
    end
    // Strap high overrides the stored standard bit, which is one here.
    @(posedge clk_i);
    strap <= 1'b1;
    settle(2);
    cmp(cfg[2].e1, 1'b0, "strap standard");
    cmp(cfg[2].tx.corner, lccr_pkg::CORNER_T1_LO, "strap corner");
    @(posedge clk_i);
    hw_e1 <= 1'b1;
    wr(adr(2, 1), 32'h00000000, r);
    settle(2);
    cmp(cfg[2].e1, 1'b1, "strap e1");
    @(posedge clk_i);
    strap <= 1'b0;
    settle(2);
    cmp(cfg[2].e1, 1'b0, "register standard");
    // Channel soft reset: transmit attenuator cleared, standard bit kept.
    wr(adr(6, 2), 32'h0000000b, r);
    wr(adr(5, 2), 32'h0000001b, r);
    wr(adr(5, 1), 32'h00000003, r);
    rd(adr(5, 1), d, r);
    cmp(d, 32'h00000003, "reset running");
    cmp(cfg[5].soft_rst, 1'b1, "reset flag");
    wr(adr(5, 2), 32'h0000001f, r);
    rd(adr(5, 2), d, r);
    cmp(d, 32'h00000000, "attenuator cleared");
    rd(adr(6, 2), d, r);
    cmp(d, 32'h0000000b, "other channel kept");
    // A write with its low byte strobe off is answered but stores nothing.
    wstrb <= 4'he;
    wr(adr(6, 2), 32'h0000001f, r);
    wstrb <= 4'hf;
    cmp(r, lccr_pkg::RESP_OKAY, "strobe off response");
    rd(adr(6, 2), d, r);
    cmp(d, 32'h0000000b, "strobe off");
    wr(adr(5, 1), 32'h00000003, r);
    n = 0;
    while (cfg[5].soft_rst !== 1'b0 && n < 200) begin
      settle(1);
      n++;
    end
    // The settings output trails the register by one clock.
    cmp(n <= 101, 1'b1, "reset length");
    rd(adr(5, 1), d, r);
    cmp(d, 32'h00000001, "self clear");
    cmp(cfg[5].e1, 1'b1, "standard kept");
    wr(adr(5, 2), 32'h00000009, r);
    rd(adr(5, 2), d, r);
    cmp(d, 32'h00000009, "write after reset");
    // Clock enable low freezes the settings although the strap changes.
    @(posedge clk_i);
    ce_i <= 1'b0;
    strap <= 1'b1;
    settle(3);
    cmp(cfg[2].e1, 1'b0, "frozen by enable");
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle(2);
    cmp(cfg[2].e1, 1'b1, "enable resumed");
    @(posedge clk_i);
    strap <= 1'b0;
    // Device reset in mid-run returns the standard bit to its default.
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    settle(1);
    cmp(cfg[5].e1, 1'b0, "device reset");
    rd(adr(5, 1), d, r);
    cmp(d, 32'h00000000, "device reset read");
    final_report();
  end
endmodule : lccr_regs_tb_top
